/* File: rtl/pct_cfg.svh */
`ifndef PCT_CFG_SVH
`define PCT_CFG_SVH

// register indexes on the plain register port
`define PCT_ADDR_W 4
`define PCT_DATA_W 16
`define PCT_REG_CTRL 4'h0
`define PCT_REG_CNT 4'h1
`define PCT_REG_MOD 4'h2
`define PCT_REG_CNTIN 4'h3
`define PCT_REG_C0V 4'h4
`define PCT_REG_C1V 4'h5
`define PCT_REG_CH0SC 4'h6
`define PCT_REG_CH1SC 4'h7
`define PCT_REG_FAULT 4'h8
`define PCT_REG_OUTINIT 4'h9
`define PCT_REG_CMD 4'hA

// control register fields
`define PCT_CTRL_CLKSRC_LO 0
`define PCT_CTRL_PS_LO 2
`define PCT_CTRL_EN_BIT 5
`define PCT_CTRL_DECAP_BIT 6
`define PCT_CTRL_COMB_BIT 7
`define PCT_CTRL_CENTER_BIT 8
`define PCT_CTRL_INITTRG_BIT 9
`define PCT_CTRL_FMODE_LO 10
`define PCT_CTRL_RELOAD_BIT 12

// channel status/control fields
`define PCT_CHSC_IE_BIT 0
`define PCT_CHSC_FLAG_BIT 1
`define PCT_CHSC_ELS_LO 2

// fault register and command fields
`define PCT_FLT_FLAG_BIT 0
`define PCT_FLT_IN_BIT 1
`define PCT_CMD_SWINIT_BIT 0
`define PCT_CMD_SYNC_BIT 1

// reset values
`define PCT_RST_CTRL 16'h0000
`define PCT_RST_MOD 16'hFFFF
`define PCT_RST_CNTIN 16'h0000
`define PCT_RST_CV 16'h0000
`define PCT_RST_CNT 16'h0000

`endif

/* File: rtl/pct_pkg.sv */
package pct_pkg;
	typedef logic [15:0] pct_word_t;
	typedef logic [3:0] pct_addr_t;
	typedef enum logic [1:0] {
		PCT_FM_OFF,
		PCT_FM_MAN_A,
		PCT_FM_MAN_B,
		PCT_FM_AUTO
	} pct_fmode_t;
endpackage

/* File: rtl/pct_timer.sv */
// Chosen here: the placing of the registers and strobed register access.
`timescale 1ns/100ps
// Overview of operation
// - paired mode needs enable, no decap, combine, edge
// - even and odd channel make one output
// - period is modulo minus initial plus one
// - pulse width is compare value difference
// - compare match sets flag, interrupt if enabled
// - select 1:0 low at start/odd, high even
// - select X:1 high at start/odd, low even
// - odd channel level select bits ignored
// - manual fault: re-enable after clear and new cycle
// - match triggers only in paired mode
// - trigger on automatic reload when enabled
// - debug halt freezes counter and outputs
// - counter write reloads counter, resets outputs
// - sync with reinitialize reloads and resets outputs
// - software init forces output initial bit
// - any chip reset resets whole timer
// - counter, prescaler zero and stopped after reset
// - flags zero, channels input capture after reset
// - outputs zero, pins released after reset
`include "pct_cfg.svh"

module pct_timer (
	input wire logic I_REF_CLK,
	input wire logic I_RSTN,
	input wire logic I_CE,
	input wire logic I_DEBUG_HALT,
	input wire logic I_FAULT,
	input wire pct_pkg::pct_addr_t I_ADDR,
	input wire pct_pkg::pct_word_t I_WDATA,
	input wire logic I_WR,
	input wire logic I_RD,
	output pct_pkg::pct_word_t O_RDATA,
	output logic O_PWM,
	output logic O_PWM_OE,
	output logic O_CH0_IRQ,
	output logic O_CH1_IRQ,
	output logic O_MATCH_TRIG0,
	output logic O_MATCH_TRIG1,
	output logic O_INIT_TRIG
);
	import pct_pkg::*;

	pct_word_t ctrl_r;
	pct_word_t cnt_r;
	pct_word_t cnt_nxt;
	pct_word_t mod_r;
	pct_word_t cntin_r;
	pct_word_t c0v_r;
	pct_word_t c1v_r;
	logic [1:0] ie_r;
	logic [1:0] flag_r;
	logic [1:0] els0_r;
	logic [1:0] els1_r;
	logic [1:0] oi_r;
	logic fault_flag_r;
	logic fault_dis_r;
	logic [6:0] ps_r;
	logic [6:0] ps_lim;
	logic tick;
	logic reload;
	logic comb_mode;
	logic running;
	logic cnt_wr;
	logic sync_reinitialize;
	logic sw_init;
	logic match0;
	logic match1;
	logic start_lvl;
	pct_fmode_t fmode;

	function automatic logic hit(input pct_addr_t a, input pct_addr_t reg_a, input logic stb);
		hit = stb && (a == reg_a);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// decode of mode and commands

	assign comb_mode = ctrl_r[`PCT_CTRL_EN_BIT] && !ctrl_r[`PCT_CTRL_DECAP_BIT]
		&& ctrl_r[`PCT_CTRL_COMB_BIT] && !ctrl_r[`PCT_CTRL_CENTER_BIT];
	assign running = (ctrl_r[`PCT_CTRL_CLKSRC_LO +: 2] != 2'b00);
	assign fmode = pct_fmode_t'(ctrl_r[`PCT_CTRL_FMODE_LO +: 2]);
	assign cnt_wr = hit(I_ADDR, `PCT_REG_CNT, I_WR);
	assign sw_init = hit(I_ADDR, `PCT_REG_CMD, I_WR) && I_WDATA[`PCT_CMD_SWINIT_BIT];
	assign sync_reinitialize = hit(I_ADDR, `PCT_REG_CMD, I_WR) && I_WDATA[`PCT_CMD_SYNC_BIT]
		&& ctrl_r[`PCT_CTRL_RELOAD_BIT];
	assign ps_lim = 7'((8'h01 << ctrl_r[`PCT_CTRL_PS_LO +: 3]) - 8'h01);
	assign tick = running && !I_DEBUG_HALT && (ps_r == ps_lim);
	assign reload = tick && (cnt_r == mod_r);
	assign cnt_nxt = reload ? cntin_r : 16'(cnt_r + 16'h0001);
	// match on the value the counter enters
	assign match0 = tick && (cnt_nxt == c0v_r);
	assign match1 = tick && (cnt_nxt == c1v_r);
	// only the even channel select shapes the output
	assign start_lvl = els0_r[0];

	////////////////////////////////////////////////////////////////////////
	// register writes

	always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			ctrl_r <= `PCT_RST_CTRL;
			mod_r <= `PCT_RST_MOD;
			cntin_r <= `PCT_RST_CNTIN;
			c0v_r <= `PCT_RST_CV;
			c1v_r <= `PCT_RST_CV;
			ie_r <= 2'h0;
			els0_r <= 2'h0;
			els1_r <= 2'h0;
			oi_r <= 2'h0;
		end else if (I_CE && I_WR) begin
			if (I_ADDR == `PCT_REG_CTRL) begin
				ctrl_r <= I_WDATA;
			end else if (I_ADDR == `PCT_REG_MOD) begin
				mod_r <= I_WDATA;
			end else if (I_ADDR == `PCT_REG_CNTIN) begin
				cntin_r <= I_WDATA;
			end else if (I_ADDR == `PCT_REG_C0V) begin
				c0v_r <= I_WDATA;
			end else if (I_ADDR == `PCT_REG_C1V) begin
				c1v_r <= I_WDATA;
			end else if (I_ADDR == `PCT_REG_CH0SC) begin
				ie_r[0] <= I_WDATA[`PCT_CHSC_IE_BIT];
				els0_r <= I_WDATA[`PCT_CHSC_ELS_LO +: 2];
			end else if (I_ADDR == `PCT_REG_CH1SC) begin
				ie_r[1] <= I_WDATA[`PCT_CHSC_IE_BIT];
				els1_r <= I_WDATA[`PCT_CHSC_ELS_LO +: 2];
			end else if (I_ADDR == `PCT_REG_OUTINIT) begin
				oi_r <= I_WDATA[1:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// prescaler and counter

	always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			ps_r <= 7'h00;
			cnt_r <= `PCT_RST_CNT;
		end else if (I_CE) begin
			if (cnt_wr || sync_reinitialize) begin
				ps_r <= 7'h00;
				cnt_r <= cntin_r;
			end else if (running && !I_DEBUG_HALT) begin
				ps_r <= tick ? 7'h00 : 7'(ps_r + 7'h01);
				if (tick) begin
					cnt_r <= cnt_nxt;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// channel flags, one per channel

	genvar g;
	generate
		for (g = 0; g < 2; g = g + 1) begin : g_flag
			logic m;
			logic clr;
			assign m = (g == 0) ? match0 : match1;
			assign clr = hit(I_ADDR, (g == 0) ? `PCT_REG_CH0SC : `PCT_REG_CH1SC, I_WR)
				&& !I_WDATA[`PCT_CHSC_FLAG_BIT];
			always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
				if (!I_RSTN) begin
					flag_r[g] <= 1'b0;
				end else if (I_CE) begin
					if (m) begin
						flag_r[g] <= 1'b1;
					end else if (clr) begin
						flag_r[g] <= 1'b0;
					end
				end
			end
		end
	endgenerate

	always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			O_CH0_IRQ <= 1'b0;
			O_CH1_IRQ <= 1'b0;
		end else if (I_CE) begin
			O_CH0_IRQ <= flag_r[0] && ie_r[0];
			O_CH1_IRQ <= flag_r[1] && ie_r[1];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// triggers

	always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			O_MATCH_TRIG0 <= 1'b0;
			O_MATCH_TRIG1 <= 1'b0;
			O_INIT_TRIG <= 1'b0;
		end else if (I_CE) begin
			O_MATCH_TRIG0 <= match0 && comb_mode;
			O_MATCH_TRIG1 <= match1 && comb_mode;
			O_INIT_TRIG <= reload && ctrl_r[`PCT_CTRL_INITTRG_BIT];
		end else begin
			O_MATCH_TRIG0 <= 1'b0;
			O_MATCH_TRIG1 <= 1'b0;
			O_INIT_TRIG <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// fault control

	always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			fault_flag_r <= 1'b0;
			fault_dis_r <= 1'b0;
		end else if (I_CE) begin
			// clear allowed only while the fault input is low or fault control is off
			if (I_FAULT && fmode != PCT_FM_OFF) begin
				fault_flag_r <= 1'b1;
			end else if (hit(I_ADDR, `PCT_REG_FAULT, I_WR) && !I_WDATA[`PCT_FLT_FLAG_BIT]) begin
				fault_flag_r <= 1'b0;
			end
			// re-enable at a new cycle once the flag is clear (auto mode: at any new cycle), or at once when fault control is off
			if (I_FAULT && fmode != PCT_FM_OFF) begin
				fault_dis_r <= 1'b1;
			end else if (fmode == PCT_FM_OFF) begin
				fault_dis_r <= 1'b0;
			end else if (reload && fmode != PCT_FM_AUTO && !fault_flag_r) begin
				fault_dis_r <= 1'b0;
			end else if (reload && fmode == PCT_FM_AUTO) begin
				fault_dis_r <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// even channel output

	always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			O_PWM <= 1'b0;
			O_PWM_OE <= 1'b0;
		end else if (I_CE) begin
			// single waveform on the even pin
			O_PWM_OE <= comb_mode && (els0_r != 2'b00) && !fault_dis_r;
			if (cnt_wr || sync_reinitialize || sw_init) begin
				O_PWM <= oi_r[0];
			end else if (!comb_mode) begin
				O_PWM <= 1'b0;
			end else if (tick) begin
				// width set by the two compare points
				if (match1) begin
					O_PWM <= start_lvl;
				end else if (match0) begin
					O_PWM <= !start_lvl;
				end else if (reload) begin
					O_PWM <= start_lvl;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read port, data one cycle after the strobe

	always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			O_RDATA <= 16'h0000;
		end else if (I_CE) begin
			if (!I_RD) begin
				O_RDATA <= 16'h0000;
			end else if (I_ADDR == `PCT_REG_CTRL) begin
				O_RDATA <= ctrl_r;
			end else if (I_ADDR == `PCT_REG_CNT) begin
				O_RDATA <= cnt_r;
			end else if (I_ADDR == `PCT_REG_MOD) begin
				O_RDATA <= mod_r;
			end else if (I_ADDR == `PCT_REG_CNTIN) begin
				O_RDATA <= cntin_r;
			end else if (I_ADDR == `PCT_REG_C0V) begin
				O_RDATA <= c0v_r;
			end else if (I_ADDR == `PCT_REG_C1V) begin
				O_RDATA <= c1v_r;
			end else if (I_ADDR == `PCT_REG_CH0SC) begin
				O_RDATA <= {12'h000, els0_r, flag_r[0], ie_r[0]};
			end else if (I_ADDR == `PCT_REG_CH1SC) begin
				O_RDATA <= {12'h000, els1_r, flag_r[1], ie_r[1]};
			end else if (I_ADDR == `PCT_REG_FAULT) begin
				O_RDATA <= {14'h0000, I_FAULT, fault_flag_r};
			end else if (I_ADDR == `PCT_REG_OUTINIT) begin
				O_RDATA <= {14'h0000, oi_r};
			end else begin
				O_RDATA <= 16'h0000;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks

	property p_mode_gate;
		@(posedge I_REF_CLK) disable iff (!I_RSTN)
		O_PWM_OE |-> $past(comb_mode);
	endproperty
	a_mode_gate: assert property (p_mode_gate) else $error("pin driven outside paired mode");

	property p_wrap;
		@(posedge I_REF_CLK) disable iff (!I_RSTN)
		(I_CE && reload && !cnt_wr && !sync_reinitialize) |=> (cnt_r == $past(cntin_r));
	endproperty
	a_wrap: assert property (p_wrap) else $error("counter did not reload at modulo");

	property p_flag0;
		@(posedge I_REF_CLK) disable iff (!I_RSTN)
		(I_CE && match0) |=> flag_r[0]
			##1 (O_CH0_IRQ == ($past(I_CE) ? $past(ie_r[0]) : $past(O_CH0_IRQ)));
	endproperty
	a_flag0: assert property (p_flag0) else $error("even match flag or irq wrong");

	property p_odd_level;
		@(posedge I_REF_CLK) disable iff (!I_RSTN)
		(I_CE && comb_mode && match1 && !cnt_wr && !sync_reinitialize && !sw_init)
			|=> (O_PWM == $past(els0_r[0]));
	endproperty
	a_odd_level: assert property (p_odd_level) else $error("odd match level wrong");

	property p_even_level;
		@(posedge I_REF_CLK) disable iff (!I_RSTN)
		(I_CE && comb_mode && match0 && !match1 && !cnt_wr && !sync_reinitialize && !sw_init)
			|=> (O_PWM != $past(els0_r[0]));
	endproperty
	a_even_level: assert property (p_even_level) else $error("even match level wrong");

	property p_halt;
		@(posedge I_REF_CLK) disable iff (!I_RSTN)
		(I_DEBUG_HALT && !cnt_wr && !sync_reinitialize && !sw_init)
			|=> $stable(cnt_r) && $stable(O_PWM);
	endproperty
	a_halt: assert property (p_halt) else $error("counter or output moved in halt");

	property p_cnt_write;
		@(posedge I_REF_CLK) disable iff (!I_RSTN)
		(I_CE && cnt_wr) |=> (cnt_r == $past(cntin_r)) && (O_PWM == $past(oi_r[0]));
	endproperty
	a_cnt_write: assert property (p_cnt_write) else $error("counter write did not reset");

	property p_swinit;
		@(posedge I_REF_CLK) disable iff (!I_RSTN)
		(I_CE && sw_init) |=> (O_PWM == $past(oi_r[0]));
	endproperty
	a_swinit: assert property (p_swinit) else $error("software init level wrong");

	property p_trig;
		@(posedge I_REF_CLK) disable iff (!I_RSTN)
		O_MATCH_TRIG0 || O_MATCH_TRIG1 |-> $past(comb_mode) && $past(tick);
	endproperty
	a_trig: assert property (p_trig) else $error("match trigger outside paired mode");

	property p_init_trig;
		@(posedge I_REF_CLK) disable iff (!I_RSTN)
		(I_CE && reload && ctrl_r[`PCT_CTRL_INITTRG_BIT]) |=> O_INIT_TRIG ##1 !O_INIT_TRIG[*1];
	endproperty
	a_init_trig: assert property (p_init_trig) else $error("init trigger missing");

	property p_fault_hold;
		@(posedge I_REF_CLK) disable iff (!I_RSTN)
		(fault_dis_r && fmode != PCT_FM_AUTO && fmode != PCT_FM_OFF && fault_flag_r)
			|=> fault_dis_r;
	endproperty
	a_fault_hold: assert property (p_fault_hold) else $error("output enabled with flag set");

endmodule // pct_timer

/* File: testbench/pct_gate_model.sv */
`timescale 1ns/100ps
module pct_gate_model (
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic i_gate,
	input wire logic i_gate_oe,
	input wire logic i_trip,
	output logic o_fault,
	output logic [15:0] o_on_cycles
);
	// fault level reported straight back; the device uses it unfiltered
	assign o_fault = i_trip;
	// switch conducts only while an enabled pin drives it high
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_on_cycles <= 16'h0000;
		end else if (i_gate && i_gate_oe) begin
			o_on_cycles <= o_on_cycles + 16'h0001;
		end
	end
endmodule // pct_gate_model

/* File: testbench/testbench.sv */
`timescale 1ns/100ps
`include "pct_cfg.svh"
module testbench;
	import pct_pkg::*;
	logic clk, rstn, ce, halt, wr, rd, trip, pwm, oe, irq0, irq1, mt0, mt1, itrg;
	pct_addr_t addr;
	pct_word_t wdata, rdata, rv, rv2;
	logic [15:0] on_cycles;
	logic [31:0] seed = 32'hDBDD;
	int n_mismatch = 0;
	int checks = 0;
	int c_hi, c_t0, c_t1, c_it, cntin, c0v, c1v, modv, per;
	logic [1:0] els;
	logic itg, pv;
	logic [15:0] bad [4] = '{16'h0020, 16'h0040, 16'h0080, 16'h0100};
	logic trip_w;

	pct_timer DUT (.I_REF_CLK(clk), .I_RSTN(rstn), .I_CE(ce), .I_DEBUG_HALT(halt),
		.I_FAULT(trip_w), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd),
		.O_RDATA(rdata), .O_PWM(pwm), .O_PWM_OE(oe), .O_CH0_IRQ(irq0), .O_CH1_IRQ(irq1),
		.O_MATCH_TRIG0(mt0), .O_MATCH_TRIG1(mt1), .O_INIT_TRIG(itrg));
	pct_gate_model gate (.i_clk(clk), .i_rstn(rstn), .i_gate(pwm), .i_gate_oe(oe),
		.i_trip(trip), .o_fault(trip_w), .o_on_cycles(on_cycles));

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	function automatic int exp_on(input logic [1:0] e, input int w, input int k);
		return (e == 2'b10 ? w : per - w) * k;
	endfunction

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value %s expected %0h seen %0h", nm, exp, got);
		end
	endtask

	task automatic wr_reg(input pct_addr_t a, input pct_word_t d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task automatic rd_reg(input pct_addr_t a, output pct_word_t d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask

	// stop, load values, restart and reload so every period is whole
	task automatic setup(input logic [1:0] fm);
		wr_reg(`PCT_REG_CTRL, 16'h0000);
		wr_reg(`PCT_REG_CNTIN, 16'(cntin));
		wr_reg(`PCT_REG_MOD, 16'(modv));
		wr_reg(`PCT_REG_C0V, 16'(c0v));
		wr_reg(`PCT_REG_C1V, 16'(c1v));
		wr_reg(`PCT_REG_CH0SC, {12'h000, els, 2'b01});
		wr_reg(`PCT_REG_CH1SC, {12'h000, 2'(rnd() % 4), 2'b01});
		wr_reg(`PCT_REG_OUTINIT, 16'h0000);
		wr_reg(`PCT_REG_CTRL, 16'h10A1 | (itg ? 16'h0200 : 16'h0000) | {4'h0, fm, 10'h000});
		wr_reg(`PCT_REG_CNT, 16'h0000);
		repeat (per + 4) @(posedge clk);
	endtask

	task automatic measure(input int n);
		logic [15:0] s;
		c_t0 = 0;
		c_t1 = 0;
		c_it = 0;
		@(negedge clk);
		s = on_cycles;
		repeat (n) begin
			c_t0 += int'(mt0);
			c_t1 += int'(mt1);
			c_it += int'(itrg);
			@(negedge clk);
		end
		c_hi = int'(16'(on_cycles - s));
	endtask

	task automatic end_of_test();
		$display("checks %0d n_mismatch %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	initial begin
		repeat (40000) @(posedge clk);
		n_mismatch++;
		end_of_test();
	end

	////////////////////////////////////////////////////////////////////////
	initial begin
		rstn = 1'b0;
		ce = 1'b1;
		halt = 1'b0;
		wr = 1'b0;
		rd = 1'b0;
		trip = 1'b0;
		addr = '0;
		wdata = '0;
		repeat (12) @(posedge clk);
		rstn <= 1'b1;
		rd_reg(`PCT_REG_CTRL, rv); chk("ctrl", 16'h0000, rv);
		rd_reg(`PCT_REG_CNT, rv); chk("cnt", 16'h0000, rv);
		rd_reg(`PCT_REG_CH0SC, rv); chk("ch0sc", 16'h0000, rv);
		rd_reg(4'hF, rv); chk("unmapped", 16'h0000, rv);
		chk("outs", 7'h00, {pwm, oe, irq0, irq1, mt0, mt1, itrg});
		for (int i = 0; i < 6; i++) begin
			// first pass is the narrowest pulse right after reload
			cntin = (i == 0) ? 0 : int'(rnd() % 8);
			c0v = cntin + 1 + ((i == 0) ? 0 : int'(rnd() % 5));
			c1v = c0v + 1 + ((i == 0) ? 0 : int'(rnd() % 6));
			modv = c1v + ((i == 0) ? 0 : int'(rnd() % 4));
			per = modv - cntin + 1;
			els = (i % 3 == 0) ? 2'b10 : ((i % 3 == 1) ? 2'b01 : 2'b11);
			itg = i[0];
			setup(2'b00);
			measure(per * 4);
			chk("on_cycles", exp_on(els, c1v - c0v, 4), c_hi);
			chk("init_trig", itg ? 4 : 0, c_it);
			chk("match0", 4, c_t0);
			chk("match1", 4, c_t1);
			chk("irq", 2'b11, {irq0, irq1});
		end
		wr_reg(`PCT_REG_CH0SC, 16'h0008);
		repeat (3) @(posedge clk);
		chk("irq0_off", 1'b0, irq0);
		for (int j = 0; j < 4; j++) begin
			wr_reg(`PCT_REG_CTRL, 16'h10A1 ^ bad[j]);
			repeat (4) @(posedge clk);
			measure(per * 2);
			chk("np_trig", 0, c_t0 + c_t1);
			chk("np_on", 0, c_hi);
		end
		// clock enable low: three steps pass, the ten frozen cycles do not
		wr_reg(`PCT_REG_MOD, 16'hFFFF);
		wr_reg(`PCT_REG_CTRL, 16'h0001);
		rd_reg(`PCT_REG_CNT, rv);
		@(posedge clk);
		ce <= 1'b0;
		repeat (10) @(posedge clk);
		ce <= 1'b1;
		rd_reg(`PCT_REG_CNT, rv2); chk("ce_freeze", 16'(rv + 16'h0003), rv2);
		// frozen state, then the three events that still act
		setup(2'b00);
		halt <= 1'b1;
		repeat (3) @(posedge clk);
		rd_reg(`PCT_REG_CNT, rv);
		pv = pwm;
		repeat (per + 2) @(posedge clk);
		rd_reg(`PCT_REG_CNT, rv2); chk("halt_cnt", rv, rv2);
		chk("halt_pwm", pv, pwm);
		wr_reg(`PCT_REG_OUTINIT, 16'h0001);
		wr_reg(`PCT_REG_CNT, 16'hA5A5);
		rd_reg(`PCT_REG_CNT, rv); chk("cnt_wr", cntin, rv);
		chk("cnt_wr_pwm", 1'b1, pwm);
		wr_reg(`PCT_REG_OUTINIT, 16'h0000);
		wr_reg(`PCT_REG_CMD, 16'h0001);
		repeat (2) @(posedge clk);
		chk("swinit_pwm", 1'b0, pwm);
		// let the counter leave its initial value so the reload is visible
		halt <= 1'b0;
		repeat (2) @(posedge clk);
		halt <= 1'b1;
		wr_reg(`PCT_REG_OUTINIT, 16'h0001);
		wr_reg(`PCT_REG_CMD, 16'h0002);
		rd_reg(`PCT_REG_CNT, rv); chk("sync_cnt", cntin, rv);
		chk("sync_pwm", 1'b1, pwm);
		@(posedge clk);
		halt <= 1'b0;
		// all three clearing modes; only auto recovers without a flag clear
		for (int f = 1; f < 4; f++) begin
			setup(2'(f));
			trip <= 1'b1;
			repeat (4) @(posedge clk);
			chk("fault_oe", 1'b0, oe);
			trip <= 1'b0;
			repeat (per * 2 + 4) @(posedge clk);
			chk("fault_hold", f == 3, oe);
			rd_reg(`PCT_REG_FAULT, rv); chk("fault_reg", 2'b01, rv[1:0]);
			wr_reg(`PCT_REG_FAULT, 16'h0000);
			repeat (per + 4) @(posedge clk);
			chk("fault_back", 1'b1, oe);
		end
		rstn <= 1'b0;
		repeat (2) @(posedge clk);
		chk("rst_outs", 7'h00, {pwm, oe, irq0, irq1, mt0, mt1, itrg});
		rstn <= 1'b1;
		rd_reg(`PCT_REG_MOD, rv); chk("rst_mod", 16'hFFFF, rv);
		end_of_test();
	end
endmodule // testbench
